// *** pmc_defs.vh ***
`ifndef PMC_DEFS_VH
`define PMC_DEFS_VH

// ****************************************
// Register map
// ****************************************
`define PMC_ADDR_W 8
`define PMC_PORT_MODE_REG_ADDR 8'h91
`define PMC_DATA_W 8

// ****************************************
// Field positions
// ****************************************
`define PMC_P3_MSB 7
`define PMC_P3_LSB 6
`define PMC_P2_MSB 5
`define PMC_P2_LSB 4
`define PMC_CARD_PU_BIT 3
`define PMC_RSVD_BIT 2
`define PMC_P0_MSB 1
`define PMC_P0_LSB 0

// ****************************************
// Reset values and masks
// ****************************************
`define PMC_RESET_VAL 8'h00
`define PMC_MASK_FULL 8'hfb
`define PMC_MASK_REDUCED 8'hc8

// ****************************************
// Mode codes
// ****************************************
`define PMC_MODE_QUASI 2'h0
`define PMC_MODE_PUSH 2'h1
`define PMC_MODE_SLOW 2'h2
`define PMC_MODE_INPUT 2'h3
`define PMC_P0_STD 2'h0
`define PMC_P0_RSVD 2'h1
`define PMC_P0_SLOW 2'h2
`define PMC_P0_PUSH 2'h3

`endif

// *** pmc_pin_sel.v ***
`timescale 1ns/100ps
`include "pmc_defs.vh"

// Per-pin mode select: pins flagged in i_apply_mask follow the field,
// the rest keep the code-00 default.
module pmc_pin_sel #(
   parameter NPINS = 8
)(
   input wire [1:0] i_mode,
   input wire [NPINS-1:0] i_apply_mask,
   output wire [2*NPINS-1:0] o_pin_mode
);
   genvar g;
   generate
      for (g = 0; g < NPINS; g = g + 1)
      begin : g_pin
         assign o_pin_mode[2*g+1:2*g] = i_apply_mask[g] ? i_mode : `PMC_MODE_QUASI;
      end
   endgenerate
endmodule

// *** pmc_p0_decode.v ***
`timescale 1ns/100ps
`include "pmc_defs.vh"

// Port 0 code decode into one-hot pad controls
module pmc_p0_decode (
   input wire [1:0] i_code,
   output reg o_std,
   output reg o_slow,
   output reg o_push
);
   always @*
   begin
      o_std = 1'b0;
      o_slow = 1'b0;
      o_push = 1'b0;
      case (i_code)
         `PMC_P0_STD: o_std = 1'b1;
         `PMC_P0_SLOW: o_slow = 1'b1;
         `PMC_P0_PUSH: o_push = 1'b1;
         // Reserved code: keep standard behaviour as the safe choice
         default: o_std = 1'b1;
      endcase
   end
endmodule

// *** pmc_port_mode.v ***
// The implementer's own choice: the address-and-strobe port.
`timescale 1ns/100ps
`include "pmc_defs.vh"

module pmc_port_mode #(
   parameter FULL_VARIANT = 1,
   parameter [7:0] P3_APPLY_MASK = 8'h1b
)(
   input wire i_ref_clk,
   input wire i_rstn,
   input wire [`PMC_ADDR_W-1:0] i_addr,
   input wire [`PMC_DATA_W-1:0] i_wdata,
   input wire i_wr,
   input wire i_rd,
   output reg [`PMC_DATA_W-1:0] o_rdata,
   output reg [15:0] o_p3_pin_mode,
   output reg [1:0] o_p2_mode,
   output reg o_p0_std,
   output reg o_p0_slow,
   output reg o_p0_push,
   output reg o_card_pullup_en
);
   // ****************************************
   // Register storage
   // ****************************************
   // Reserved bits are stored as zero: "undefined" is met by reading zero
   localparam [7:0] IMPL_MASK = (FULL_VARIANT != 0) ? `PMC_MASK_FULL : `PMC_MASK_REDUCED;

   reg [7:0] port_mode_reg_q;
   reg [7:0] port_mode_reg_d;
   wire sel_w;
   wire [15:0] p3_pin_mode_w;
   wire p0_std_w;
   wire p0_slow_w;
   wire p0_push_w;
   wire [1:0] port3_mode_field;
   wire [1:0] port2_mode_field;
   wire [1:0] port0_mode_field;
   wire card_detect_pullup_off;

   assign sel_w = (i_addr == `PMC_PORT_MODE_REG_ADDR);

   always @*
   begin
      port_mode_reg_d = port_mode_reg_q;
      if (i_wr && sel_w)
      begin
         port_mode_reg_d = i_wdata & IMPL_MASK;
      end
   end

   always @(posedge i_ref_clk)
   begin
      if (!i_rstn)
      begin
         port_mode_reg_q <= `PMC_RESET_VAL;
      end
      else
      begin
         port_mode_reg_q <= port_mode_reg_d;
      end
   end

   assign port3_mode_field = port_mode_reg_q[`PMC_P3_MSB:`PMC_P3_LSB];
   assign port2_mode_field = port_mode_reg_q[`PMC_P2_MSB:`PMC_P2_LSB];
   assign port0_mode_field = port_mode_reg_q[`PMC_P0_MSB:`PMC_P0_LSB];
   assign card_detect_pullup_off = port_mode_reg_q[`PMC_CARD_PU_BIT];

   // ****************************************
   // Mode decode
   // ****************************************
   pmc_pin_sel #(
      .NPINS(8)
   ) u_p3_sel (
      .i_mode(port3_mode_field),
      .i_apply_mask(P3_APPLY_MASK),
      .o_pin_mode(p3_pin_mode_w)
   );

   pmc_p0_decode u_p0_dec (
      .i_code(port0_mode_field),
      .o_std(p0_std_w),
      .o_slow(p0_slow_w),
      .o_push(p0_push_w)
   );

   // ****************************************
   // Registered outputs
   // ****************************************
   // Outputs trail the register by one edge so every pin comes from a flop
   always @(posedge i_ref_clk)
   begin
      if (!i_rstn)
      begin
         o_rdata <= 8'h00;
         o_p3_pin_mode <= 16'h0000;
         o_p2_mode <= `PMC_MODE_QUASI;
         o_p0_std <= 1'b1;
         o_p0_slow <= 1'b0;
         o_p0_push <= 1'b0;
         o_card_pullup_en <= 1'b1;
      end
      else
      begin
         o_rdata <= (i_rd && sel_w) ? port_mode_reg_q : 8'h00;
         o_p3_pin_mode <= p3_pin_mode_w;
         o_p2_mode <= port2_mode_field;
         o_p0_std <= p0_std_w;
         o_p0_slow <= p0_slow_w;
         o_p0_push <= p0_push_w;
         o_card_pullup_en <= ~card_detect_pullup_off;
      end
   end
endmodule

// *** pmc_port_mode_assertions.sv ***
`timescale 1ns/100ps
module pmc_port_mode_chk #(
   parameter FULL_VARIANT = 1
)(
   input wire i_ref_clk,
   input wire i_rstn,
   input wire [7:0] i_addr,
   input wire [7:0] i_wdata,
   input wire i_wr,
   input wire i_rd,
   input wire [7:0] o_rdata,
   input wire [15:0] o_p3_pin_mode,
   input wire [1:0] o_p2_mode,
   input wire o_p0_std,
   input wire o_p0_slow,
   input wire o_p0_push,
   input wire o_card_pullup_en
);
   // ****
   // Write seen two edges back
   // ****
   reg [8:0] w1_q;
   reg [8:0] w2_q;
   always @(posedge i_ref_clk)
   begin
      w1_q <= i_rstn ? {i_wr && i_addr == 8'h91, i_wdata} : 9'h0;
      w2_q <= i_rstn ? w1_q : 9'h0;
   end
   default clocking @(posedge i_ref_clk); endclocking
   default disable iff (!i_rstn);
   chk_p3_pins: assert property (o_p3_pin_mode == {6'h0, {2{o_p3_pin_mode[1:0]}}, 2'h0, {2{o_p3_pin_mode[1:0]}}})
      else $error("p3 pins");
   chk_p3_write: assert property (w2_q[8] |-> o_p3_pin_mode[1:0] == w2_q[7:6]) else $error("p3 mode");
   chk_p2_write: assert property (w2_q[8] |-> o_p2_mode == (FULL_VARIANT != 0 ? w2_q[5:4] : 2'h0))
      else $error("p2 mode");
   chk_card_write: assert property (w2_q[8] |-> o_card_pullup_en == !w2_q[3]) else $error("pullup");
   chk_p0_decode: assert property (w2_q[8] && FULL_VARIANT != 0 |-> $onehot({o_p0_std, o_p0_slow, o_p0_push})
      && {o_p0_push, o_p0_slow} == {w2_q[1:0] == 2'h3, w2_q[1:0] == 2'h2}) else $error("p0 mode");
   chk_mode_hold: assert property (!w2_q[8] && $past(i_rstn) |-> $stable(o_p3_pin_mode) && $stable(o_p2_mode))
      else $error("mode hold");
   chk_rd_idle: assert property (!($past(i_rd) && $past(i_addr) == 8'h91) |-> o_rdata == 8'h0)
      else $error("rdata idle");
   chk_reset_vals: assert property (disable iff (1'b0) !i_rstn |=> o_p0_std && o_card_pullup_en
      && o_p3_pin_mode == 16'h0 && o_p2_mode == 2'h0) else $error("reset");
endmodule
bind pmc_port_mode pmc_port_mode_chk #(.FULL_VARIANT(FULL_VARIANT)) i_chk (.*);

// *** tb_port_mode_config.sv ***
`timescale 1ns/100ps
module tb_port_mode_config;
   // ****
   // Driver and scoreboard
   // ****
   logic c = 0, rn = 0, wr = 0, rd = 0, rd_q = 0;
   logic [7:0] a = 0, d = 0, r = 0;
   logic [15:0] q[$];
   int fails = 0, compares = 0, i;
   wire [7:0] ro;
   wire [15:0] p3;
   wire [1:0] p2;
   wire s0, l0, h0, cu;
   pmc_port_mode #(.FULL_VARIANT(1)) i_dut (.i_ref_clk(c), .i_rstn(rn), .i_addr(a), .i_wdata(d), .i_wr(wr),
      .i_rd(rd), .o_rdata(ro), .o_p3_pin_mode(p3), .o_p2_mode(p2), .o_p0_std(s0), .o_p0_slow(l0),
      .o_p0_push(h0), .o_card_pullup_en(cu));
   always #2 c = ~c;
   always @(posedge c) rd_q <= rd;
   always @(negedge c)
   begin
      if (rd_q) ck({ro, p3[1:0], p2, cu, h0, l0, s0}, q.pop_front());
   end
   task ck(input logic [15:0] s, e);
      compares++;
      if (s !== e)
      begin
         fails++;
         $display("wrong value t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask
   task wt(input logic [7:0] ad, dt);
      @(posedge c);
      wr <= 1;
      a <= ad;
      d <= dt;
      if (ad == 8'h91) r = dt & 8'hfb;
      @(posedge c);
      wr <= 0;
   endtask
   task rt(input logic [7:0] ad);
      @(posedge c);
      rd <= 1;
      a <= ad;
      q.push_back({(ad == 8'h91 ? r : 8'h0), r[7:4], ~r[3], r[1:0] == 2'h3, r[1:0] == 2'h2, r[1:0] < 2'h2});
      @(posedge c);
      rd <= 0;
   endtask
   task complete_run;
      $display("compares=%0d fails=%0d", compares, fails);
      if (fails == 0 && compares > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   initial
   begin
      i = $urandom(32'h2520);
      repeat (8) @(posedge c);
      rn <= 1;
      rt(8'h91);
      for (i = 0; i < 4; i++)
      begin
         wt(8'h91, {i[1:0], i[1:0], i[0], 1'b0, i[1:0]});
         rt(8'h91);
      end
      wt(8'(8'h92 + $urandom % 96), 8'h00);
      rt(8'h91);
      rt(8'(8'h10 + $urandom % 128));
      @(posedge c);
      rn <= 0;
      @(posedge c);
      rn <= 1;
      r = 8'h00;
      rt(8'h91);
      repeat (3) @(posedge c);
      if (q.size() != 0) fails++;
      complete_run;
   end
endmodule
